// ==== verilog/aic_pkg.sv ====
// Shared constants, types and helpers for the adapter I/O and I2C configuration block
package aic_pkg;

	localparam int         NUM_PORTS   = 2;
	localparam int         LINES       = 8;
	localparam int         PORT_W      = 1;
	localparam int         I2C_PORTS   = 2;
	localparam int         RATE_W      = 12;

	localparam logic [PORT_W-1:0] PORT_RST    = 1'h0;
	localparam logic [PORT_W-1:0] I2C_PORT_RST = 1'h0;
	localparam logic [LINES-1:0]  DIR_RST     = 8'h00;
	localparam logic [15:0]       TIMEOUT_RST = 16'h7530;
	localparam logic [RATE_W-1:0] RATE_RST    = 12'h064;
	localparam logic [RATE_W-1:0] HS_RATE_RST = 12'h6a4;
	localparam logic [4:0]        TEN_BIT_HDR = 5'h1e;
	localparam logic              HAS_PULLUP  = 1'h1;

	// Supported standard rates in kHz, ascending
	localparam int                RATE_N = 4;
	localparam logic [RATE_W-1:0] RATE_TBL [RATE_N] = '{12'h064, 12'h0fa, 12'h190, 12'h3e8};

	localparam int CLK_PERIOD_NS = 100;
	localparam int MS_NS         = 1000000;
	localparam int CYC_PER_MS    = MS_NS / CLK_PERIOD_NS;

	typedef enum logic [2:0] {VSEL_3V3, VSEL_2V5, VSEL_1V8, VSEL_1V5, VSEL_1V2} aic_vsel_t;
	localparam logic [2:0] VSEL_COUNT = 3'h5;

	typedef enum logic {DRV_PUSH_PULL, DRV_OPEN_DRAIN} aic_drv_t;
	typedef enum logic {ADDR_7BIT, ADDR_10BIT} aic_addr_t;

	// Returns {error, warning, rate}: largest supported rate not above the request
	function automatic logic [RATE_W+1:0] rate_fit(input logic [RATE_W-1:0] req);
		logic              found;
		logic [RATE_W-1:0] rate;
		found = 1'b0;
		rate  = RATE_TBL[0];
		for (int i = 0; i < RATE_N; i++) begin
			if (RATE_TBL[i] <= req) begin
				found = 1'b1;
				rate  = RATE_TBL[i];
			end
		end
		return {!found, found && (rate != req), rate};
	endfunction

endpackage

// ==== verilog/aic_port_if.sv ====
// Per-port DIO settings carried from the configuration core to a pin driver
`timescale 1ns/1ns
interface aic_port_if import aic_pkg::*; ();
	logic [LINES-1:0] dir;
	aic_drv_t         style;
	aic_vsel_t        vsel;
	logic [LINES-1:0] value;

	modport cfg (output dir, output style, output vsel, output value);
	modport drv (input dir, input style, input vsel, input value);
endinterface

// ==== verilog/aic_pin_drv.sv ====
// Registered pin driver for one DIO port
`timescale 1ns/1ns
module aic_pin_drv
	import aic_pkg::*;
(
	input  wire logic         clk,
	input  wire logic         sys_rst,
	aic_port_if.drv           cfg,
	output logic [LINES-1:0]  pin_out,
	output logic [LINES-1:0]  pin_oe,
	output logic [2:0]        pin_level
);

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			pin_out   <= '0;
			pin_oe    <= '0;
			pin_level <= VSEL_3V3;
		end else begin
			// RULE_18: inputs never drive
			// RULE_19: open drain releases high
			for (int i = 0; i < LINES; i++) begin
				pin_oe[i]  <= cfg.dir[i] && (cfg.style == DRV_PUSH_PULL || !cfg.value[i]);
				pin_out[i] <= (cfg.style == DRV_PUSH_PULL) && cfg.value[i];
			end
			// RULE_04: high level follows voltage
			pin_level <= cfg.vsel;
		end
	end

	a_input_no_drive: assert property (@(posedge clk) disable iff (sys_rst)
		!cfg.dir[0] |=> !pin_oe[0]) // RULE_18
		else $error("input line 0 drives its pin");

	a_od_release_high: assert property (@(posedge clk) disable iff (sys_rst)
		cfg.style == DRV_OPEN_DRAIN && cfg.value[0] |=> !pin_oe[0] && !pin_out[0]) // RULE_19
		else $error("open-drain line 0 drives high");

endmodule

// ==== verilog/aic_config.sv ====
// Adapter DIO, voltage, pull-up, timeout and I2C master configuration core
// Contract
// RULE_01: Active port selector picks target of direction and style writes; resets to 0.
// RULE_02: Single-port device: controller selects only port 0.
// RULE_03: Each port offers open-drain or push-pull style; push-pull after reset.
// RULE_04: Push-pull high level follows the selected I/O voltage.
// RULE_05: Direction bitmap bit x high makes line x an output, low an input.
// RULE_06: Direction bitmap resets to zero, all lines inputs.
// RULE_07: One voltage code (3.3 to 1.2 V) for all interfaces; 3.3 V at reset.
// RULE_08: One control switches both I2C pull-ups together where present.
// RULE_09: Global millisecond timeout, reset 30000, abandons operations.
// RULE_10: Controller should set timeout above expected operation time.
// RULE_11: I2C port index selects transfer port; resets to 0.
// RULE_12: Unsupported rate falls back to next lower supported rate with warning.
// RULE_13: Rate below lowest supported is rejected with an error.
// RULE_14: High-speed master code goes out at the standard rate.
// RULE_15: Standard I2C rate is 100 kHz after reset.
// RULE_16: 7-bit mode sends 7-bit address then direction bit.
// RULE_17: 10-bit mode uses extended addressing; 7-bit is the reset choice.
// RULE_18: An input line never drives its pin.
// RULE_19: Open-drain output driving high releases the pin.
`timescale 1ns/1ns
module aic_config
	import aic_pkg::*;
#(
	parameter int MS_CYCLES = CYC_PER_MS
)(
	input  wire logic                   clk,
	input  wire logic                   sys_rst,
	input  wire logic                   port_sel_wr,
	input  wire logic [PORT_W-1:0]      port_sel_data,
	input  wire logic                   style_wr,
	input  wire logic                   style_data,
	input  wire logic                   dir_wr,
	input  wire logic [LINES-1:0]       dir_data,
	input  wire logic [NUM_PORTS*LINES-1:0] dio_value,
	input  wire logic                   vsel_wr,
	input  wire logic [2:0]             vsel_data,
	input  wire logic                   pullup_wr,
	input  wire logic                   pullup_data,
	input  wire logic                   timeout_wr,
	input  wire logic [15:0]            timeout_data,
	input  wire logic                   op_busy,
	input  wire logic                   i2c_port_wr,
	input  wire logic [PORT_W-1:0]      i2c_port_data,
	input  wire logic                   rate_wr,
	input  wire logic [RATE_W-1:0]      rate_data,
	input  wire logic                   hs_enable,
	input  wire logic                   hs_code_phase,
	input  wire logic                   addr_size_wr,
	input  wire logic                   addr_size_data,
	input  wire logic                   addr_load,
	input  wire logic [9:0]             slave_addr,
	input  wire logic                   dir_read,
	output logic [PORT_W-1:0]           active_port_select,
	output logic                        output_driver_style,
	output logic [LINES-1:0]            line_direction_bitmap,
	output logic [NUM_PORTS*LINES-1:0]  dio_out,
	output logic [NUM_PORTS*LINES-1:0]  dio_oe,
	output logic [NUM_PORTS*3-1:0]      dio_level,
	output logic [2:0]                  io_vsel,
	output logic                        i2c_pullup_en,
	output logic [15:0]                 timeout_ms,
	output logic                        op_timeout,
	output logic [PORT_W-1:0]           i2c_port,
	output logic [RATE_W-1:0]           i2c_rate_khz,
	output logic [RATE_W-1:0]           i2c_bus_rate_khz,
	output logic                        rate_warn,
	output logic                        rate_err,
	output logic                        cfg_err,
	output logic                        addr_mode,
	output logic [7:0]                  addr_byte0,
	output logic [7:0]                  addr_byte1,
	output logic                        addr_two_bytes
);

	aic_drv_t          style_q [NUM_PORTS];
	logic [LINES-1:0]  dir_q   [NUM_PORTS];
	logic [RATE_W+1:0] fit;
	logic [15:0]       cyc_cnt;
	logic [15:0]       ms_cnt;
	logic              fired;

	assign fit = rate_fit(rate_data);

	// RULE_01: port selector, out-of-range refused
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			active_port_select <= PORT_RST;
		end else if (port_sel_wr && int'(port_sel_data) < NUM_PORTS) begin
			active_port_select <= port_sel_data;
		end
	end

	// RULE_03: per-port style, push-pull at reset
	// RULE_05: direction map per port
	// RULE_06: direction clears at reset
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			for (int p = 0; p < NUM_PORTS; p++) begin
				style_q[p] <= DRV_PUSH_PULL;
				dir_q[p]   <= DIR_RST;
			end
		end else begin
			if (style_wr) begin
				style_q[active_port_select] <= aic_drv_t'(style_data);
			end
			if (dir_wr) begin
				dir_q[active_port_select] <= dir_data;
			end
		end
	end

	// Read-back lags a write by one cycle
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			output_driver_style   <= DRV_PUSH_PULL;
			line_direction_bitmap <= DIR_RST;
		end else begin
			output_driver_style   <= style_q[active_port_select];
			line_direction_bitmap <= dir_q[active_port_select];
		end
	end

	// RULE_07: one shared voltage code, invalid codes refused
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			io_vsel <= VSEL_3V3;
		end else if (vsel_wr && vsel_data < VSEL_COUNT) begin
			io_vsel <= vsel_data;
		end
	end

	// RULE_08: both pull-ups share one switch
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			i2c_pullup_en <= 1'b0;
		end else if (pullup_wr) begin
			i2c_pullup_en <= pullup_data && HAS_PULLUP;
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			cfg_err <= 1'b0;
		end else begin
			cfg_err <= (port_sel_wr && int'(port_sel_data) >= NUM_PORTS)
				|| (vsel_wr && vsel_data >= VSEL_COUNT)
				|| (i2c_port_wr && int'(i2c_port_data) >= I2C_PORTS);
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			timeout_ms <= TIMEOUT_RST;
		end else if (timeout_wr) begin
			timeout_ms <= timeout_data;
		end
	end

	// RULE_09: elapsed time only counts while busy; fires once per operation
	always_ff @(posedge clk) begin
		if (sys_rst || !op_busy) begin
			cyc_cnt    <= '0;
			ms_cnt     <= '0;
			fired      <= 1'b0;
			op_timeout <= 1'b0;
		end else begin
			op_timeout <= !fired && ms_cnt >= timeout_ms;
			if (ms_cnt >= timeout_ms) begin
				fired <= 1'b1;
			end
			if (cyc_cnt == 16'(MS_CYCLES - 1)) begin
				cyc_cnt <= '0;
				if (ms_cnt != 16'hffff) begin
					ms_cnt <= ms_cnt + 16'h0001;
				end
			end else begin
				cyc_cnt <= cyc_cnt + 16'h0001;
			end
		end
	end

	// RULE_11: I2C port index, resets to 0
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			i2c_port <= I2C_PORT_RST;
		end else if (i2c_port_wr && int'(i2c_port_data) < I2C_PORTS) begin
			i2c_port <= i2c_port_data;
		end
	end

	// RULE_12: fall back with warning
	// RULE_13: too-low request keeps old rate
	// RULE_15: 100 kHz after reset
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			i2c_rate_khz <= RATE_RST;
			rate_warn    <= 1'b0;
			rate_err     <= 1'b0;
		end else begin
			rate_warn <= rate_wr && fit[RATE_W];
			rate_err  <= rate_wr && fit[RATE_W+1];
			if (rate_wr && !fit[RATE_W+1]) begin
				i2c_rate_khz <= fit[RATE_W-1:0];
			end
		end
	end

	// RULE_14: master code phase uses the standard rate
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			i2c_bus_rate_khz <= RATE_RST;
		end else begin
			i2c_bus_rate_khz <= (hs_enable && !hs_code_phase) ? HS_RATE_RST : i2c_rate_khz;
		end
	end

	// RULE_17: 7-bit addressing at reset
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			addr_mode <= ADDR_7BIT;
		end else if (addr_size_wr) begin
			addr_mode <= addr_size_data;
		end
	end

	// RULE_16: 7-bit address then direction
	// RULE_17: 10-bit header byte then low address byte
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			addr_byte0     <= 8'h00;
			addr_byte1     <= 8'h00;
			addr_two_bytes <= 1'b0;
		end else if (addr_load) begin
			if (addr_mode == ADDR_10BIT) begin
				addr_byte0     <= {TEN_BIT_HDR, slave_addr[9:8], dir_read};
				addr_byte1     <= slave_addr[7:0];
				addr_two_bytes <= 1'b1;
			end else begin
				addr_byte0     <= {slave_addr[6:0], dir_read};
				addr_byte1     <= 8'h00;
				addr_two_bytes <= 1'b0;
			end
		end
	end

	for (genvar g = 0; g < NUM_PORTS; g++) begin : g_port
		aic_port_if pif ();
		assign pif.dir   = dir_q[g];
		assign pif.style = style_q[g];
		assign pif.vsel  = aic_vsel_t'(io_vsel);
		assign pif.value = dio_value[g*LINES +: LINES];
		aic_pin_drv u_drv (
			.clk       (clk),
			.sys_rst   (sys_rst),
			.cfg       (pif.drv),
			.pin_out   (dio_out[g*LINES +: LINES]),
			.pin_oe    (dio_oe[g*LINES +: LINES]),
			.pin_level (dio_level[g*3 +: 3])
		);
	end

	a_port_select_load: assert property (@(posedge clk) disable iff (sys_rst)
		port_sel_wr && int'(port_sel_data) < NUM_PORTS |=> active_port_select == $past(port_sel_data)) // RULE_01
		else $error("active port not loaded");
	a_style_reset_pp: assert property (@(posedge clk) disable iff (sys_rst)
		$fell(sys_rst) |-> style_q[0] == DRV_PUSH_PULL && style_q[1] == DRV_PUSH_PULL) // RULE_03
		else $error("driver style not push-pull after reset");
	a_dir_reset_zero: assert property (@(posedge clk) disable iff (sys_rst)
		$fell(sys_rst) |-> dir_q[0] == DIR_RST && dir_q[1] == DIR_RST && io_vsel == VSEL_3V3) // RULE_06
		else $error("direction or voltage wrong after reset");
	a_dir_write_port: assert property (@(posedge clk) disable iff (sys_rst)
		dir_wr |=> dir_q[$past(active_port_select)] == $past(dir_data)) // RULE_05
		else $error("direction map not written to active port");
	a_vsel_reject: assert property (@(posedge clk) disable iff (sys_rst)
		vsel_wr && vsel_data >= VSEL_COUNT |=> $stable(io_vsel) && cfg_err) // RULE_07
		else $error("invalid voltage code accepted");
	a_timeout_idle: assert property (@(posedge clk) disable iff (sys_rst)
		!op_busy |=> !op_timeout ##1 (op_busy || !op_timeout)) // RULE_09
		else $error("timeout while idle");
	a_rate_fallback: assert property (@(posedge clk) disable iff (sys_rst)
		rate_wr && fit[RATE_W] |=> rate_warn && i2c_rate_khz < $past(rate_data)) // RULE_12
		else $error("rate fallback missing");
	a_rate_too_low: assert property (@(posedge clk) disable iff (sys_rst)
		rate_wr && rate_data < RATE_TBL[0] |=> rate_err && $stable(i2c_rate_khz)) // RULE_13
		else $error("too-low rate not rejected");
	a_code_std_rate: assert property (@(posedge clk) disable iff (sys_rst)
		hs_enable && hs_code_phase |=> i2c_bus_rate_khz == $past(i2c_rate_khz)) // RULE_14
		else $error("master code not at standard rate");
	a_addr_seven: assert property (@(posedge clk) disable iff (sys_rst)
		addr_load && addr_mode == ADDR_7BIT
		|=> addr_byte0 == {$past(slave_addr[6:0]), $past(dir_read)} && !addr_two_bytes) // RULE_16
		else $error("7-bit address byte wrong");

endmodule

// ==== test/aic_dio_far.sv ====
// Far-side model of the DIO lines: external pull-ups on every line
`timescale 1ns/1ns
module aic_dio_far
	import aic_pkg::*;
(
	input  wire logic [NUM_PORTS*LINES-1:0] drive,
	input  wire logic [NUM_PORTS*LINES-1:0] enable,
	output logic      [NUM_PORTS*LINES-1:0] pin
);
	// Released lines rest high, so a stuck enable shows as a low pin
	assign pin = (drive & enable) | ~enable;
endmodule

// ==== test/adapter_io_and_i2c_config_tb.sv ====
// Self-checking bench for the configuration core
`timescale 1ns/1ns
module adapter_io_and_i2c_config_tb import aic_pkg::*; ;
	localparam int MS = 4;
	logic clk = 0, sys_rst = 1;
	logic port_sel_wr = 0, style_wr = 0, dir_wr = 0, vsel_wr = 0, pullup_wr = 0;
	logic timeout_wr = 0, op_busy = 0, i2c_port_wr = 0, rate_wr = 0, addr_size_wr = 0;
	logic addr_load = 0, hs_enable = 0, hs_code_phase = 0, dir_read = 0;
	logic port_sel_data = 0, style_data = 0, pullup_data = 0, i2c_port_data = 0;
	logic addr_size_data = 0;
	logic [7:0] dir_data = 8'h00;
	logic [15:0] dio_value = 16'h0000, timeout_data = 16'h0000;
	logic [2:0] vsel_data = 3'h0;
	logic [11:0] rate_data = 12'h000;
	logic [9:0] slave_addr = 10'h000;
	logic aps, ods, op_timeout, rate_warn, rate_err, cfg_err, addr_mode, two, pu;
	logic [7:0] ldb, b0, b1;
	logic [15:0] dio_out, dio_oe, pin, tmo;
	logic [5:0] lvl;
	logic [2:0] vsel;
	logic ip;
	logic [11:0] rate, bus_rate;
	int n_fail = 0, n_compared = 0;
	logic [31:0] seed = 32'h0001_18b6;
	logic [7:0] dir_m [2];
	logic sty_m [2];
	logic port_m;
	logic [2:0] vs_m;
	logic [11:0] rate_m;
	logic [13:0] er;
	logic [31:0] r;
	int k;
	aic_config #(.MS_CYCLES(MS)) u_dut (.clk(clk), .sys_rst(sys_rst),
		.port_sel_wr(port_sel_wr), .port_sel_data(port_sel_data), .style_wr(style_wr),
		.style_data(style_data), .dir_wr(dir_wr), .dir_data(dir_data),
		.dio_value(dio_value), .vsel_wr(vsel_wr), .vsel_data(vsel_data),
		.pullup_wr(pullup_wr), .pullup_data(pullup_data), .timeout_wr(timeout_wr),
		.timeout_data(timeout_data), .op_busy(op_busy), .i2c_port_wr(i2c_port_wr),
		.i2c_port_data(i2c_port_data), .rate_wr(rate_wr), .rate_data(rate_data),
		.hs_enable(hs_enable), .hs_code_phase(hs_code_phase), .addr_size_wr(addr_size_wr),
		.addr_size_data(addr_size_data), .addr_load(addr_load), .slave_addr(slave_addr),
		.dir_read(dir_read), .active_port_select(aps), .output_driver_style(ods),
		.line_direction_bitmap(ldb), .dio_out(dio_out), .dio_oe(dio_oe), .dio_level(lvl),
		.io_vsel(vsel), .i2c_pullup_en(pu), .timeout_ms(tmo), .op_timeout(op_timeout),
		.i2c_port(ip), .i2c_rate_khz(rate), .i2c_bus_rate_khz(bus_rate),
		.rate_warn(rate_warn), .rate_err(rate_err), .cfg_err(cfg_err),
		.addr_mode(addr_mode), .addr_byte0(b0), .addr_byte1(b1), .addr_two_bytes(two));
	aic_dio_far u_far (.drive(dio_out), .enable(dio_oe), .pin(pin));
	always #50 clk = ~clk;
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	// Expected {error, warning, rate} for a requested rate
	function automatic logic [13:0] exp_rate(input logic [11:0] q, input logic [11:0] old);
		logic [11:0] f;
		if (q < 12'h064) return {2'b10, old};
		f = q < 12'h0fa ? 12'h064 : q < 12'h190 ? 12'h0fa : q < 12'h3e8 ? 12'h190 : 12'h3e8;
		return {1'b0, f != q, f};
	endfunction
	task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		n_compared++;
		if (g !== e) begin
			n_fail++;
			$display("BAD %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	// Commit the strobes on one edge, then drop them all
	task automatic pulse();
		cyc(1);
		{port_sel_wr, style_wr, dir_wr, vsel_wr, pullup_wr, timeout_wr} = 0;
		{i2c_port_wr, rate_wr, addr_size_wr, addr_load} = 0;
	endtask
	task automatic conclude();
		$display("compared %0d mismatches %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	// Time the abandon pulse for a timeout of t ms and a busy span of len cycles
	task automatic op_run(input logic [15:0] t, input int len, input int exp_at);
		int seen;
		seen = 0;
		timeout_data = t;
		timeout_wr = 1;
		pulse();
		op_busy = 1;
		for (int c = 1; c <= len; c++) begin
			cyc(1);
			if (op_timeout === 1'b1) seen = seen == 0 ? c : -1;
		end
		op_busy = 0;
		chk("op_timeout", exp_at, seen);
		cyc(2);
	endtask
	initial begin
		cyc(8);
		sys_rst = 0;
		chk("aps", 0, aps);
		chk("ods", DRV_PUSH_PULL, ods);
		chk("ldb", 0, ldb);
		chk("oe", 0, dio_oe);
		chk("vsel", VSEL_3V3, vsel);
		chk("tmo", 16'h7530, tmo);
		chk("i2c_port", 0, ip);
		chk("rate", 12'h064, rate);
		chk("mode", ADDR_7BIT, addr_mode);
		dir_m = '{8'h00, 8'h00};
		sty_m = '{1'b0, 1'b0};
		port_m = 0;
		vs_m = 0;
		rate_m = 12'h064;
		// random DIO traffic, port write racing style and map
		for (int i = 0; i < 60; i++) begin
			r = rnd();
			{port_sel_wr, port_sel_data, style_wr, style_data, dir_wr, vsel_wr} = r[5:0];
			dir_data = r[15:8];
			dio_value = r[31:16];
			vsel_data = 3'(rnd() % 5);
			if (style_wr) sty_m[port_m] = style_data;
			if (dir_wr) dir_m[port_m] = dir_data;
			if (vsel_wr) vs_m = vsel_data;
			if (port_sel_wr) port_m = port_sel_data;
			pulse();
			cyc(2);
			chk("aps", port_m, aps);
			chk("ods", sty_m[port_m], ods);
			chk("ldb", dir_m[port_m], ldb);
			chk("vsel", vs_m, vsel);
			for (int p = 0; p < 2; p++) begin
				r[7:0] = dio_value[8*p+:8];
				chk("oe", dir_m[p] & (sty_m[p] ? ~r[7:0] : 8'hff), dio_oe[8*p+:8]);
				chk("out", sty_m[p] ? 8'h00 : r[7:0], dio_out[8*p+:8]);
				chk("pin", 8'(~dir_m[p] | r[7:0]), pin[8*p+:8]);
				if (!sty_m[p]) chk("lvl", vs_m, lvl[3*p+:3]);
			end
		end
		// every voltage code, bad codes refused
		for (int v = 0; v < 8; v++) begin
			vsel_data = 3'(v);
			vsel_wr = 1;
			pulse();
			chk("cfg_err", v > 4, cfg_err);
			if (v < 5) vs_m = 3'(v);
			cyc(1);
			chk("vsel", vs_m, vsel);
		end
		// pull-up switch and I2C port index
		for (int v = 0; v < 3; v++) begin
			pullup_data = v[0];
			i2c_port_data = ~v[0];
			{pullup_wr, i2c_port_wr} = 2'b11;
			pulse();
			cyc(1);
			chk("pullup", v[0], pu);
			chk("i2c_port", !v[0], ip);
		end
		// rate fit, corner requests then random ones
		for (int i = 0; i < 24; i++) begin
			k = i;
			rate_data = i < 8 ? 12'(k * 137) : 12'(rnd() % 1500);
			if (i == 1) rate_data = 12'h063;
			if (i == 2) rate_data = 12'h0fa;
			er = exp_rate(rate_data, rate_m);
			rate_wr = 1;
			pulse();
			chk("rate_err", er[13], rate_err);
			chk("rate_warn", er[12], rate_warn);
			chk("rate", er[11:0], rate);
			rate_m = er[11:0];
			// Strobe must not be dropped and raised in one step
			cyc(1);
		end
		// master code at the standard rate
		hs_enable = 1;
		hs_code_phase = 1;
		cyc(2);
		chk("bus_rate", rate_m, bus_rate);
		hs_code_phase = 0;
		cyc(2);
		chk("bus_rate", 12'h6a4, bus_rate);
		hs_enable = 0;
		for (int i = 0; i < 16; i++) begin
			r = rnd();
			addr_size_data = r[0];
			dir_read = r[1];
			slave_addr = r[11:2];
			addr_size_wr = 1;
			cyc(1);
			addr_size_wr = 0;
			addr_load = 1;
			pulse();
			cyc(1);
			chk("mode", r[0], addr_mode);
			chk("b0", r[0] ? {5'h1e, r[11:10], r[1]} : {r[8:2], r[1]}, b0);
			chk("b1", r[0] ? r[9:2] : 8'h00, b1);
			chk("two", r[0], two);
		end
		// abandon after timeout, limits 0 and 3 ms
		op_run(16'h0003, 20, 3 * MS + 1);
		op_run(16'h0000, 6, 1);
		// timeout set equal to the operation time
		op_run(16'h0003, 3 * MS, 0);
		conclude();
	end
	initial begin
		#2000000;
		n_fail++;
		conclude();
	end
endmodule
